// ===== core/rsfo_top.sv
/*
  Frame builder, UART transmitter, I2C slave and byte FIFO for the
  range sensor host link. Measurements arrive as a one-cycle strobe
  from the ranging core; configuration arrives as plain inputs.
*/
`timescale 1ns/1ps

module rsfo_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp;
  logic [AW:0]      rp;
  wire              full  = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  wire              empty = (wp == rp);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp[AW-1:0]];
  always_ff @(posedge clock) begin
    if (in_valid && !full) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst || flush) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (in_valid && !full) begin
        wp <= wp + 1'b1;
      end
      if (out_ready && !empty) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule

// Function
// RULE1: Serial link is 115200 baud, 8 data bits, 1 stop, no parity.
// RULE2: Binary frame is nine bytes opening with two 0x59 headers.
// RULE3: Bytes 2..7 carry distance, amplitude, temperature, low byte first.
// RULE4: Ninth byte is the low eight bits of the sum of bytes 0..7.
// RULE5: Binary or ASCII encoding; binary after reset, switchable by input.
// RULE6: ASCII mode sends distance in metres followed by CR LF.
// RULE7: Distance is unsigned centimetres, clamped to 0..1200.
// RULE8: Amplitude below 100 or equal 65535 forces distance to zero.
// RULE9: Amplitude field is sent as full 16-bit unsigned value.
// RULE10: Temperature field equals (celsius + 256) times 8.
// RULE11: Bus mode is I2C slave only; master stays at or below 400k.
// RULE12: Slave address resets to 0x10, configurable 0x01 to 0x7F.
// RULE13: Mode input swaps UART and I2C; RX is SDA, TX is SCL.
// RULE14: In I2C mode nothing is sent unless the master reads.
// RULE15: UART frames go out at 1000/n Hz, 100 Hz after reset.
// RULE16: ASCII shows whole metres, a point and two fractional digits.
// RULE17: Bytes of one frame leave back to back without idle gaps.
module rsfo_top
  import rsfo_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        meas_valid,
  input  wire logic [15:0] meas_dist,
  input  wire logic [15:0] meas_amp,
  input  wire logic [15:0] meas_temp_c8,
  input  wire logic        cfg_ascii,
  input  wire logic        cfg_i2c,
  input  wire logic [9:0]  cfg_rate_n,
  input  wire logic        cfg_addr_load,
  input  wire logic [6:0]  cfg_addr,
  input  wire logic        rx_sda_in,
  output logic             rx_sda_out,
  output logic             rx_sda_oe,
  input  wire logic        tx_scl_in,
  output logic             tx_scl_out,
  output logic             tx_scl_oe,
  output logic             fifo_overrun
);
  import rsfo_pkg::*;

  // ----------------------------------------------------------------
  // Measurement capture and validity
  // ----------------------------------------------------------------
  logic [15:0] dist_q;
  logic [15:0] amp_q;
  logic [15:0] temp_q;
  logic        have_meas;
  logic [15:0] next_dist;
  always_comb begin
    next_dist = (meas_dist > DIST_MAX) ? DIST_MAX : meas_dist; // RULE7
    if (meas_amp < AMP_MIN || meas_amp == AMP_SAT) begin
      next_dist = 16'h0000; // RULE8
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      dist_q    <= 16'h0000;
      amp_q     <= 16'h0000;
      temp_q    <= 16'h0000;
      have_meas <= 1'b0;
    end else if (meas_valid) begin
      dist_q    <= next_dist;
      amp_q     <= meas_amp; // RULE9
      temp_q    <= meas_temp_c8; // RULE10
      have_meas <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration: mode, address, frame rate
  // ----------------------------------------------------------------
  logic       ascii_mode;
  logic       i2c_mode;
  logic [6:0] slave_addr;
  logic [9:0] rate_n;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ascii_mode <= 1'b0; // RULE5
      i2c_mode   <= 1'b0;
      slave_addr <= I2C_ADDR_RST; // RULE12
      rate_n     <= RATE_N_RESET; // RULE15
    end else begin
      ascii_mode <= cfg_ascii; // RULE5
      i2c_mode   <= cfg_i2c; // RULE13
      if (cfg_addr_load && cfg_addr >= I2C_ADDR_MIN) begin
        slave_addr <= cfg_addr; // RULE12
      end
      if (cfg_rate_n != 10'h000) begin
        rate_n <= cfg_rate_n; // RULE15
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame rate tick: 1 kHz base divided by n
  // ----------------------------------------------------------------
  logic [16:0] base_cnt;
  logic [9:0]  rate_cnt;
  logic        frame_tick;
  wire         base_tick = (base_cnt == 17'(RATE_BASE_CYC - 1));
  always_ff @(posedge clock) begin
    if (!nrst) begin
      base_cnt   <= '0;
      rate_cnt   <= 10'h000;
      frame_tick <= 1'b0;
    end else begin
      frame_tick <= 1'b0;
      base_cnt   <= base_tick ? '0 : base_cnt + 1'b1;
      if (base_tick) begin
        if (rate_cnt + 10'h001 >= rate_n) begin
          rate_cnt   <= 10'h000;
          frame_tick <= !i2c_mode; // RULE15 RULE14
        end else begin
          rate_cnt <= rate_cnt + 10'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame builder
  // ----------------------------------------------------------------
  // Tail formed from distance: whole metres up to 12, then two digits
  logic [3:0]  metres;
  logic [6:0]  frac;
  logic [7:0]  asc [8];
  logic [3:0]  asc_len;
  logic [7:0]  bin [FRAME_LEN];
  always_comb begin
    metres = 4'(dist_q / 16'd100);
    frac   = 7'(dist_q % 16'd100);
    bin[0] = HDR_BYTE; // RULE2
    bin[1] = HDR_BYTE;
    bin[2] = dist_q[7:0]; // RULE3
    bin[3] = dist_q[15:8];
    bin[4] = amp_q[7:0];
    bin[5] = amp_q[15:8];
    bin[6] = temp_q[7:0];
    bin[7] = temp_q[15:8];
    bin[8] = 8'(bin[0] + bin[1] + bin[2] + bin[3] + bin[4] + bin[5] + bin[6] + bin[7]); // RULE4
    for (int k = 0; k < 8; k++) begin
      asc[k] = 8'h00;
    end
    if (metres >= 4'd10) begin
      asc[0]  = ASC_ZERO + 8'(metres / 4'd10); // RULE16
      asc[1]  = ASC_ZERO + 8'(metres % 4'd10);
      asc[2]  = ASC_DOT;
      asc[3]  = ASC_ZERO + 8'(frac / 7'd10);
      asc[4]  = ASC_ZERO + 8'(frac % 7'd10);
      asc[5]  = ASC_CR; // RULE6
      asc[6]  = ASC_LF;
      asc_len = 4'd7;
    end else begin
      asc[0]  = ASC_ZERO + 8'(metres);
      asc[1]  = ASC_DOT;
      asc[2]  = ASC_ZERO + 8'(frac / 7'd10);
      asc[3]  = ASC_ZERO + 8'(frac % 7'd10);
      asc[4]  = ASC_CR; // RULE6
      asc[5]  = ASC_LF;
      asc_len = 4'd6;
    end
  end

  // Frame is pushed one byte per clock, far ahead of the UART, so the UART never waits mid-frame
  logic       push_busy;
  logic [3:0] push_idx;
  logic [3:0] push_len;
  logic       push_ascii;
  logic [7:0] push_byte;
  logic       fifo_in_ready;
  logic       fifo_flush;
  always_comb begin
    push_byte = push_ascii ? asc[push_idx[2:0]] : bin[push_idx];
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      push_busy    <= 1'b0;
      push_idx     <= 4'd0;
      push_len     <= 4'd0;
      push_ascii   <= 1'b0;
      fifo_overrun <= 1'b0;
    end else begin
      fifo_overrun <= 1'b0;
      if (!push_busy && frame_tick && have_meas) begin
        push_busy  <= 1'b1;
        push_idx   <= 4'd0;
        push_ascii <= ascii_mode;
        push_len   <= ascii_mode ? asc_len : 4'(FRAME_LEN); // RULE2
      end else if (push_busy && fifo_in_ready) begin
        push_idx <= push_idx + 4'd1;
        if (push_idx == push_len - 4'd1) begin
          push_busy <= 1'b0;
        end
      end
      // A tick that lands while the previous frame is still being queued is dropped
      if (push_busy && frame_tick) begin
        fifo_overrun <= 1'b1;
      end
    end
  end
  assign fifo_flush = i2c_mode;

  // ----------------------------------------------------------------
  // UART transmitter, 8N1
  // ----------------------------------------------------------------
  logic [7:0] fifo_out;
  logic       fifo_out_valid;
  logic       uart_take;
  logic [9:0] sh;
  logic [3:0] bit_cnt;
  logic [10:0] baud_cnt;
  logic       tx_line;
  wire        uart_idle = (bit_cnt == 4'd0);
  assign uart_take = uart_idle && fifo_out_valid && !i2c_mode;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sh       <= 10'h3FF;
      bit_cnt  <= 4'd0;
      baud_cnt <= 11'd0;
      tx_line  <= 1'b1;
    end else if (uart_take) begin
      sh       <= {1'b1, fifo_out, 1'b0}; // RULE1
      bit_cnt  <= 4'(1 + DATA_BITS + STOP_BITS);
      baud_cnt <= 11'(BAUD_DIV - 1);
      tx_line  <= 1'b0;
    end else if (!uart_idle) begin
      if (baud_cnt == 11'd0) begin
        baud_cnt <= 11'(BAUD_DIV - 1); // RULE1
        sh       <= {1'b1, sh[9:1]};
        tx_line  <= sh[1];
        bit_cnt  <= bit_cnt - 4'd1;
      end else begin
        baud_cnt <= baud_cnt - 11'd1;
      end
    end else begin
      tx_line <= 1'b1;
    end
  end

  rsfo_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .flush     (fifo_flush),
    .in_data   (push_byte),
    .in_valid  (push_busy),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (uart_take) // RULE17
  );

  // ----------------------------------------------------------------
  // I2C slave: reads return the latest binary frame
  // ----------------------------------------------------------------
  logic [1:0] sda_s;
  logic [1:0] scl_s;
  logic       sda_d;
  logic       scl_d;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sda_s <= 2'b11;
      scl_s <= 2'b11;
      sda_d <= 1'b1;
      scl_d <= 1'b1;
    end else begin
      sda_s <= {sda_s[0], rx_sda_in};
      scl_s <= {scl_s[0], tx_scl_in};
      sda_d <= sda_s[1];
      scl_d <= scl_s[1];
    end
  end
  wire sda  = sda_s[1];
  wire scl  = scl_s[1];
  wire start_c = i2c_mode && scl && scl_d && sda_d && !sda;
  wire stop_c  = i2c_mode && scl && scl_d && !sda_d && sda;
  wire scl_r   = scl && !scl_d;
  wire scl_f   = !scl && scl_d;

  typedef enum logic [4:0] {
    RSFO_I_IDLE  = 5'b00001,
    RSFO_I_ADDR  = 5'b00010,
    RSFO_I_ACK   = 5'b00100,
    RSFO_I_TX    = 5'b01000,
    RSFO_I_MACK  = 5'b10000
  } rsfo_i2c_t;
  rsfo_i2c_t  ist;
  logic [7:0] ish;
  logic [2:0] icnt;
  logic       iread;
  logic [3:0] iidx;
  logic       sda_drive;
  logic       iaddr_done;
  always_ff @(posedge clock) begin
    if (!nrst || !i2c_mode) begin
      ist       <= RSFO_I_IDLE;
      ish       <= 8'h00;
      icnt      <= 3'd0;
      iread     <= 1'b0;
      iidx      <= 4'd0;
      sda_drive <= 1'b0;
      iaddr_done <= 1'b0;
    end else if (start_c) begin
      ist       <= RSFO_I_ADDR; // RULE11
      icnt      <= 3'd0;
      sda_drive <= 1'b0;
      iaddr_done <= 1'b0;
    end else if (stop_c) begin
      ist       <= RSFO_I_IDLE;
      sda_drive <= 1'b0;
    end else begin
      case (ist)
        RSFO_I_IDLE: begin
          sda_drive <= 1'b0; // RULE14
        end
        RSFO_I_ADDR: begin
          if (scl_r) begin
            ish        <= {ish[6:0], sda};
            icnt       <= icnt + 3'd1;
            iaddr_done <= (icnt == 3'h7);
          end
          // The fall right after START also sees a zero count, so wait for eight rises
          if (scl_f && iaddr_done) begin
            if (ish[7:1] == slave_addr) begin // RULE12
              iread     <= ish[0];
              iidx      <= 4'd0;
              sda_drive <= 1'b1;
              ist       <= RSFO_I_ACK;
            end else begin
              ist <= RSFO_I_IDLE;
            end
          end
        end
        RSFO_I_ACK: begin
          if (scl_f) begin
            if (iread) begin
              ish       <= bin[iidx];
              sda_drive <= !bin[iidx][7];
              icnt      <= 3'd0;
              ist       <= RSFO_I_TX;
            end else begin
              sda_drive <= 1'b0;
              ist       <= RSFO_I_IDLE;
            end
          end
        end
        RSFO_I_TX: begin
          if (scl_f) begin
            icnt <= icnt + 3'd1;
            if (icnt == 3'd7) begin
              sda_drive <= 1'b0;
              ist       <= RSFO_I_MACK;
            end else begin
              ish       <= {ish[6:0], 1'b0};
              sda_drive <= !ish[6];
            end
          end
        end
        RSFO_I_MACK: begin
          if (scl_r) begin
            iread <= !sda;
          end
          if (scl_f) begin
            if (iread) begin
              iidx      <= (iidx == 4'(FRAME_LEN - 1)) ? 4'd0 : iidx + 4'd1;
              ish       <= bin[(iidx == 4'(FRAME_LEN - 1)) ? 4'd0 : iidx + 4'd1];
              sda_drive <= !bin[(iidx == 4'(FRAME_LEN - 1)) ? 4'd0 : iidx + 4'd1][7];
              icnt      <= 3'd0;
              ist       <= RSFO_I_TX;
            end else begin
              ist <= RSFO_I_IDLE;
            end
          end
        end
        default: begin
          ist <= RSFO_I_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin sharing: UART drives TX push-pull, I2C pulls SDA only low
  // ----------------------------------------------------------------
  assign tx_scl_out = i2c_mode ? 1'b0 : tx_line; // RULE13
  assign tx_scl_oe  = !i2c_mode;
  assign rx_sda_out = 1'b0;
  assign rx_sda_oe  = i2c_mode && sda_drive; // RULE14

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_dist_forced: assert property (@(posedge clock) disable iff (!nrst) // RULE8
    meas_valid && (meas_amp < AMP_MIN || meas_amp == AMP_SAT) |=> dist_q == 16'h0000)
    else $error("distance not zeroed on weak signal");
  chk_dist_clamp: assert property (@(posedge clock) disable iff (!nrst) // RULE7
    dist_q <= DIST_MAX)
    else $error("distance above limit");
  chk_bin_hdr: assert property (@(posedge clock) disable iff (!nrst) // RULE2
    push_busy && !push_ascii && push_idx < 4'd2 |-> push_byte == HDR_BYTE)
    else $error("header byte wrong");
  chk_frame_len: assert property (@(posedge clock) disable iff (!nrst) // RULE2
    !push_busy && frame_tick && have_meas && !ascii_mode |=> push_len == 4'd9)
    else $error("binary frame length wrong");
  chk_quiet_i2c: assert property (@(posedge clock) disable iff (!nrst) // RULE14
    ist == RSFO_I_IDLE |-> !rx_sda_oe)
    else $error("slave drives bus while idle");
  chk_tx_start: assert property (@(posedge clock) disable iff (!nrst) // RULE1
    uart_take |=> !tx_line [*8])
    else $error("start bit too short");
  chk_addr_reset: assert property (@(posedge clock) // RULE12
    !nrst |=> slave_addr == I2C_ADDR_RST)
    else $error("address reset value wrong");
  chk_back_to_back: assert property (@(posedge clock) disable iff (!nrst) // RULE17
    bit_cnt == 4'h1 && baud_cnt == 11'h000 && fifo_out_valid && !i2c_mode
      |=> uart_take ##1 !tx_line)
    else $error("idle gap between bytes");
endmodule

// ===== core/rsfo_pkg.sv
/*
  Constants for the range sensor frame output block.
  Assumes a single 125 MHz clock.
*/
package rsfo_pkg;
  localparam int          CLK_HZ        = 125000000;
  localparam int          BAUD_DEFAULT  = 115200;
  localparam int          BAUD_DIV      = CLK_HZ / BAUD_DEFAULT;
  localparam int          DATA_BITS     = 8;
  localparam int          STOP_BITS     = 1;
  localparam int          FRAME_LEN     = 9;
  localparam logic [7:0]  HDR_BYTE      = 8'h59;
  localparam logic [15:0] DIST_MAX      = 16'h04B0;
  localparam logic [15:0] AMP_MIN       = 16'h0064;
  localparam logic [15:0] AMP_SAT       = 16'hFFFF;
  localparam int          TEMP_DIV      = 8;
  localparam int          TEMP_OFS      = 256;
  localparam int          RATE_BASE_HZ  = 1000;
  localparam int          RATE_BASE_CYC = CLK_HZ / RATE_BASE_HZ;
  localparam logic [9:0]  RATE_N_RESET  = 10'h00A;
  localparam int          I2C_MAX_BPS   = 400000;
  localparam logic [6:0]  I2C_ADDR_RST  = 7'h10;
  localparam logic [6:0]  I2C_ADDR_MIN  = 7'h01;
  localparam logic [7:0]  ASC_ZERO      = 8'h30;
  localparam logic [7:0]  ASC_DOT       = 8'h2E;
  localparam logic [7:0]  ASC_CR        = 8'h0D;
  localparam logic [7:0]  ASC_LF        = 8'h0A;
  localparam int          FIFO_DEPTH    = 32;
  localparam int          FIFO_WIDTH    = 8;
endpackage

// ===== test/rsfo_host.sv
/*
  Host model for the range sensor link: a UART receiver and an I2C master.
  Assumes the bench resolves the open-drain wires and feeds them back here.
*/
`timescale 1ns/1ps

module rsfo_host
  import rsfo_pkg::*;
(
  input  wire logic clock,
  input  wire logic listen,
  input  wire logic tx_line,
  input  wire logic sda,
  output logic      sda_low,
  output logic      scl_low
);
  // Quarter bit of 80 cycles keeps SCL just under the bus limit
  localparam int Q = 80;

  logic [7:0]  rx_q[$];
  int unsigned st_q[$];
  logic [7:0]  rd_q[$];
  int unsigned cyc       = 0;
  int          frame_err = 0;
  logic [9:0]  sh;

  initial begin
    sda_low = 1'b0;
    scl_low = 1'b0;
  end

  always @(posedge clock) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // UART receiver, samples mid-bit
  // ----------------------------------------------------------------
  always begin
    @(negedge tx_line);
    if (listen) begin
      st_q.push_back(cyc);
      repeat (BAUD_DIV / 2) @(posedge clock);
      for (int i = 0; i < 10; i++) begin
        sh[i] = tx_line;
        if (i < 9) repeat (BAUD_DIV) @(posedge clock);
      end
      if (sh[0] !== 1'b0 || sh[9] !== 1'b1) frame_err++;
      rx_q.push_back(sh[8:1]);
    end
  end

  // ----------------------------------------------------------------
  // I2C master
  // ----------------------------------------------------------------
  task automatic wq();
    repeat (Q) @(posedge clock);
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    wq();
    scl_low <= 1'b0;
    wq();
    r = sda;
    wq();
    scl_low <= 1'b1;
    wq();
  endtask

  task automatic byte_io(input logic [7:0] w, input logic ack_in,
                         output logic [7:0] r, output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(ack_in, ack_out);
  endtask

  // The master owns every transfer; the device only answers
  task automatic i2c_read(input logic [6:0] a, input int n, output logic nak);
    logic [7:0] r;
    logic       k;
    rd_q.delete();
    sda_low <= 1'b1;
    wq();
    scl_low <= 1'b1;
    wq();
    byte_io({a, 1'b1}, 1'b1, r, nak);
    for (int i = 0; i < n && !nak; i++) begin
      byte_io(8'hFF, i == n - 1, r, k);
      rd_q.push_back(r);
    end
    sda_low <= 1'b1;
    wq();
    scl_low <= 1'b0;
    wq();
    sda_low <= 1'b0;
    wq();
  endtask
endmodule

// ===== test/tb.sv
/*
  Self-checking bench for the range sensor frame output block.
  Assumes the host model in rsfo_host and the 125 MHz clock of the package.
*/
`timescale 1ns/1ps

module tb;
  import rsfo_pkg::*;

  logic        clock         = 1'b0;
  logic        nrst          = 1'b0;
  logic        meas_valid    = 1'b0;
  logic [15:0] meas_dist     = 16'h0000;
  logic [15:0] meas_amp      = 16'h0000;
  logic [15:0] meas_temp_c8  = 16'h0000;
  logic        cfg_ascii     = 1'b0;
  logic        cfg_i2c       = 1'b0;
  logic [9:0]  cfg_rate_n    = 10'h001;
  logic        cfg_addr_load = 1'b0;
  logic [6:0]  cfg_addr      = 7'h10;
  logic        rx_sda_out;
  logic        rx_sda_oe;
  logic        tx_scl_out;
  logic        tx_scl_oe;
  logic        fifo_overrun;
  logic        sda_low;
  logic        scl_low;
  logic        sda;
  logic        scl;
  int          mismatches    = 0;
  int          checks        = 0;
  int          overruns      = 0;
  int unsigned last_start    = 0;
  logic [7:0]  exp_q[$];

  // Pulled-up open-drain SDA; SCL is the UART line while the device drives it
  assign sda = !rx_sda_oe && !sda_low;
  assign scl = (tx_scl_oe ? tx_scl_out : 1'b1) && !scl_low;

  always #4 clock = ~clock;
  always @(posedge clock) if (fifo_overrun === 1'b1) overruns++;

  rsfo_top dut_u (
    .clock         (clock),
    .nrst          (nrst),
    .meas_valid    (meas_valid),
    .meas_dist     (meas_dist),
    .meas_amp      (meas_amp),
    .meas_temp_c8  (meas_temp_c8),
    .cfg_ascii     (cfg_ascii),
    .cfg_i2c       (cfg_i2c),
    .cfg_rate_n    (cfg_rate_n),
    .cfg_addr_load (cfg_addr_load),
    .cfg_addr      (cfg_addr),
    .rx_sda_in     (sda),
    .rx_sda_out    (rx_sda_out),
    .rx_sda_oe     (rx_sda_oe),
    .tx_scl_in     (scl),
    .tx_scl_out    (tx_scl_out),
    .tx_scl_oe     (tx_scl_oe),
    .fifo_overrun  (fifo_overrun)
  );

  rsfo_host host_u (
    .clock   (clock),
    .listen  (!cfg_i2c),
    .tx_line (scl),
    .sda     (sda),
    .sda_low (sda_low),
    .scl_low (scl_low)
  );

  // ----------------------------------------------------------------
  // Compare and drive helpers
  // ----------------------------------------------------------------
  task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp1(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic send_meas(input logic [15:0] d, input logic [15:0] a, input logic [15:0] t);
    host_u.rx_q.delete();
    host_u.st_q.delete();
    @(posedge clock);
    meas_valid   <= 1'b1;
    meas_dist    <= d;
    meas_amp     <= a;
    meas_temp_c8 <= t;
    @(posedge clock);
    meas_valid <= 1'b0;
  endtask

  // Generous bound: longer than a whole frame period even at the reset rate
  task automatic wait_bytes(input int n);
    int k;
    k = 0;
    while (host_u.rx_q.size() < n && k < 1400000) begin
      @(posedge clock);
      k++;
    end
    cmp1("byte_count", 1'b1, host_u.rx_q.size() == n);
  endtask

  task automatic build_bin(input logic [15:0] d, input logic [15:0] a, input logic [15:0] t);
    logic [15:0] e;
    logic [7:0]  s;
    e = (d > DIST_MAX) ? DIST_MAX : d;
    if (a < AMP_MIN || a == AMP_SAT) e = 16'h0000;
    exp_q = '{HDR_BYTE, HDR_BYTE, e[7:0], e[15:8], a[7:0], a[15:8], t[7:0], t[15:8]};
    s = 8'h00;
    foreach (exp_q[i]) s += exp_q[i];
    exp_q.push_back(s);
  endtask

  task automatic cmp_bin(input logic [7:0] g[$]);
    cmp8("header0", exp_q[0], g[0]);
    cmp8("header1", exp_q[1], g[1]);
    for (int i = 2; i < 8; i++) cmp8("field_byte", exp_q[i], g[i]);
    cmp8("checksum", exp_q[8], g[8]);
  endtask

  task automatic load_addr(input logic [6:0] a);
    @(posedge clock);
    cfg_addr      <= a;
    cfg_addr_load <= 1'b1;
    @(posedge clock);
    cfg_addr_load <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_bin(input logic [15:0] d, input logic [15:0] a, input logic [15:0] t);
    int unsigned gap;
    build_bin(d, a, t);
    send_meas(d, a, t);
    wait_bytes(FRAME_LEN);
    cmp_bin(host_u.rx_q);
    for (int i = 1; i < FRAME_LEN; i++) begin
      gap = host_u.st_q[i] - host_u.st_q[i - 1];
      cmp1("byte_spacing", 1'b1, gap >= 10 * BAUD_DIV && gap <= 10 * BAUD_DIV + 2);
    end
    if (last_start != 0) begin
      cmp1("frame_period", 1'b1, host_u.st_q[0] - last_start == RATE_BASE_CYC);
    end
    last_start = host_u.st_q[0];
    cmp8("stop_errors", 8'h00, host_u.frame_err[7:0]);
  endtask

  task automatic t_ascii(input logic [15:0] d);
    int m;
    int f;
    m = d / 100;
    f = d % 100;
    exp_q.delete();
    if (m >= 10) exp_q.push_back(ASC_ZERO + 8'(m / 10));
    exp_q.push_back(ASC_ZERO + 8'(m % 10));
    exp_q.push_back(ASC_DOT);
    exp_q.push_back(ASC_ZERO + 8'(f / 10));
    exp_q.push_back(ASC_ZERO + 8'(f % 10));
    exp_q.push_back(ASC_CR);
    exp_q.push_back(ASC_LF);
    cfg_ascii <= 1'b1;
    send_meas(d, 16'h01F4, 16'h0A00);
    wait_bytes(exp_q.size());
    foreach (exp_q[i]) cmp8("ascii_char", exp_q[i], host_u.rx_q[i]);
    cfg_ascii <= 1'b0;
  endtask

  task automatic t_i2c();
    logic nak;
    int   busy;
    busy = 0;
    cfg_i2c <= 1'b1;
    build_bin(16'h0320, 16'h0063, 16'h0B00);
    send_meas(16'h0320, 16'h0063, 16'h0B00);
    repeat (3) @(posedge clock);
    cmp1("scl_released", 1'b0, tx_scl_oe);
    cmp1("sda_out_level", 1'b0, rx_sda_out);
    repeat (RATE_BASE_CYC + 1000) begin
      @(posedge clock);
      if (rx_sda_oe !== 1'b0 || tx_scl_oe !== 1'b0) busy++;
    end
    cmp1("unsolicited", 1'b1, busy == 0);
    host_u.i2c_read(I2C_ADDR_RST, FRAME_LEN, nak);
    cmp1("addr_ack", 1'b0, nak);
    cmp_bin(host_u.rd_q);
    load_addr(7'h7F);
    host_u.i2c_read(I2C_ADDR_RST, 1, nak);
    cmp1("old_addr_nak", 1'b1, nak);
    load_addr(7'h00);
    host_u.i2c_read(7'h7F, 1, nak);
    cmp1("new_addr_ack", 1'b0, nak);
  endtask

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (2000000) @(posedge clock);
    mismatches++;
    tally_and_finish();
  end

  // Rate divisor 1 keeps each frame period at one millisecond
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    cmp1("tx_idle", 1'b1, tx_scl_out);
    t_bin(16'h05DC, 16'h0064, 16'h0A00);
    t_bin(16'h012C, 16'hFFFF, 16'h0A28);
    t_ascii(16'h03ED);
    t_i2c();
    cmp1("no_overrun", 1'b1, overruns == 0);
    tally_and_finish();
  end
endmodule
